//--- ipe_isp_engine.sv
/*
 ipe_isp_engine: i2c slave that takes programming commands
 and turns them into memory requests, stretching scl while
 storage runs.
 assumes scl and sda arrive asynchronously (open drain, wired
 outside), a memory that reads combinationally from
 mem_rd_addr, and a memory side that accepts requests with
 valid/ready on clk.
*/
`default_nettype none

module ipe_isp_engine
   import ipe_pkg::*;
#(
   parameter int ERASE_CYC = ERASE_CYCLES,
   parameter int PROG_CYC = PROG_CYCLES
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   output logic mem_valid,
   input wire logic mem_ready,
   output ipe_mem_req_t mem_req,
   output logic [13:0] mem_rd_addr,
   input wire logic [7:0] mem_rd_data,
   input wire logic lock_at_entry,
   output logic locked
);

   ////////////////////////////////////////////////////////////
   // types and constants

   // link states
   typedef enum logic [2:0] {
      S_IDLE, S_ADDR, S_AACK, S_RX, S_RACK, S_HOLD, S_TX, S_TACK
   } ipe_link_t;
   // command parser phase
   typedef enum logic [1:0] {P_CMD, P_ARG1, P_ARG2, P_DATA} ipe_parse_t;
   // what a read returns
   typedef enum logic [1:0] {RD_NONE, RD_MEM, RD_STAT} ipe_rdk_t;

   // whole module state
   typedef struct packed {
      ipe_link_t st;
      logic [1:0] scl_sy; // scl synchroniser
      logic [1:0] sda_sy; // sda synchroniser
      logic scl_q; // scl one cycle late
      logic sda_q; // sda one cycle late
      logic [3:0] bitn; // bit count in byte
      logic [7:0] sh; // receive shifter
      logic ack; // drive ack low
      logic rw; // 1 = master reads
      logic open; // mode byte seen
      ipe_parse_t ps;
      logic [7:0] cmd; // command in progress
      logic [4:0] idx; // data byte in block
      ipe_ptr_t cur; // current pointer
      logic [13:0] rd_adr; // read / byte target
      ipe_rdk_t rdk;
      logic [7:0] tx; // transmit shifter
      logic locked;
      logic init; // entry lock sampled
      logic pend; // request waiting to queue
      ipe_mem_req_t preq; // that request
      logic [HOLD_W-1:0] hold; // stretch cycles left
      ipe_mem_req_t [1:0] q; // two-entry buffer
      logic [1:0] fill; // entries in buffer
   } ipe_state_t;

   // hold lengths in cycles
   localparam logic [HOLD_W-1:0] T_E = HOLD_W'(ERASE_CYC);
   localparam logic [HOLD_W-1:0] T_P = HOLD_W'(PROG_CYC);
   localparam logic [HOLD_W-1:0] T_EP = HOLD_W'(ERASE_CYC + PROG_CYC);
   localparam ipe_ptr_t RESET_PTR = '{RESET_PAGE, RESET_BLOCK, RESET_BYTE};

   ipe_state_t r_reg; // registered state
   ipe_state_t r_next; // next state

   ////////////////////////////////////////////////////////////
   // pointer arithmetic

   // block increment with page carry
   function automatic ipe_ptr_t blk_inc(input ipe_ptr_t p);
      ipe_ptr_t q;
      q = p;
      if (p.page == LAST_SEQ_PAGE && p.blk == LAST_BLOCK) begin
         q = '0;
      end else begin
         q.blk = p.blk + 3'h1;
         if (p.blk == LAST_BLOCK) begin
            q.page = p.page + 6'h1;
         end
      end
      return q;
   endfunction : blk_inc

   // absolute address increment
   function automatic ipe_ptr_t ptr_inc(input ipe_ptr_t p);
      ipe_ptr_t q;
      if (p == ipe_ptr_t'{LAST_SEQ_PAGE, LAST_BLOCK, LAST_BYTE}) begin
         q = '0;
      end else begin
         q = ipe_ptr_t'(14'(p) + 14'h1);
      end
      return q;
   endfunction : ptr_inc

   ////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      logic rise;
      logic fall;
      logic start;
      logic stop;
      logic sda_v;
      logic pop;
      logic [1:0] fidx;
      logic [7:0] b;
      logic ok;
      rise = r_reg.scl_sy[1] & ~r_reg.scl_q;
      fall = ~r_reg.scl_sy[1] & r_reg.scl_q;
      sda_v = r_reg.sda_sy[1];
      // start/stop: sda edge while scl high
      start = r_reg.scl_sy[1] & r_reg.scl_q & r_reg.sda_q & ~sda_v;
      stop = r_reg.scl_sy[1] & r_reg.scl_q & ~r_reg.sda_q & sda_v;
      pop = (r_reg.fill != 2'h0) & mem_ready;
      fidx = 2'h0;
      b = {r_reg.sh[6:0], sda_v};
      ok = 1'b1;
      r_next = r_reg;
      // pin sampling, two flops then edge flops
      r_next.scl_sy = {r_reg.scl_sy[0], scl_i};
      r_next.sda_sy = {r_reg.sda_sy[0], sda_i};
      r_next.scl_q = r_reg.scl_sy[1];
      r_next.sda_q = sda_v;
      // lock state caught once after reset release
      if (!r_reg.init) begin
         r_next.init = 1'b1;
         r_next.locked = lock_at_entry;
      end
      // buffer drain toward memory
      if (pop) begin
         r_next.q[0] = r_reg.q[1];
      end
      unique case (r_reg.st)
         S_IDLE: begin
            // wait for start
         end
         S_ADDR: begin
            if (rise) begin
               r_next.sh = b;
               r_next.bitn = r_reg.bitn + 4'h1;
            end else if (fall && r_reg.bitn == 4'h8) begin
               r_next.bitn = 4'h0;
               // match fixed address
               if (r_reg.sh[7:1] == SLAVE_ADDR) begin
                  r_next.ack = 1'b1;
                  r_next.rw = r_reg.sh[0];
                  r_next.st = S_AACK;
               end else begin
                  r_next.st = S_IDLE;
               end
            end
         end
         S_AACK: begin
            if (fall) begin
               r_next.ack = 1'b0;
               r_next.bitn = 4'h0;
               if (r_reg.rw) begin
                  // load byte to send
                  r_next.st = S_TX;
                  r_next.tx = (r_reg.rdk == RD_STAT) ?
                     {r_reg.locked, 7'h00} : mem_rd_data;
                  r_next.rdk = RD_NONE;
               end else begin
                  // mode byte only once per entry
                  r_next.st = S_RX;
                  r_next.ps = P_CMD;
               end
            end
         end
         S_RX: begin
            if (rise) begin
               r_next.sh = b;
               r_next.bitn = r_reg.bitn + 4'h1;
            end else if (fall && r_reg.bitn == 4'h8) begin
               r_next.bitn = 4'h0;
               r_next.st = S_RACK;
               if (!r_reg.open) begin
                  // first byte must be mode code
                  ok = (r_reg.sh == MODE_CODE);
                  r_next.open = ok;
               end else begin
                  unique case (r_reg.ps)
                     P_CMD: begin
                        r_next.cmd = r_reg.sh;
                        r_next.idx = 5'h00;
                        unique case (r_reg.sh)
                           ERASE_THEN_WRITE_BLOCK_CMD: begin
                              // clear block first, data follows
                              r_next.ps = P_DATA;
                              r_next.pend = 1'b1;
                              r_next.preq = '{OP_CLR_BLOCK,
                                 {r_reg.cur.page, r_reg.cur.blk, 5'h00}, 8'h00};
                           end
                           NO_ERASE_BLOCK_PROGRAM_CMD: begin
                              r_next.ps = P_DATA;
                           end
                           SINGLE_BYTE_PROGRAM_CMD, BLOCK_CLEAR_CMD,
                           SINGLE_BYTE_CLEAR_CMD, ADDRESSED_READ_CMD,
                           LOAD_PAGE_POINTER_CMD: begin
                              r_next.ps = P_ARG1;
                           end
                           FULL_MEMORY_CLEAR_CMD: begin
                              r_next.pend = 1'b1;
                              r_next.preq = '{OP_CLR_ALL, 14'h0000, 8'h00};
                              r_next.hold = T_E;
                              r_next.locked = 1'b0;
                           end
                           SEQUENTIAL_READ_CMD: begin
                              // return current, then advance
                              r_next.rd_adr = r_reg.cur;
                              r_next.rdk = RD_MEM;
                              r_next.cur = ptr_inc(r_reg.cur);
                           end
                           ADVANCE_BLOCK_POINTER_CMD: begin
                              r_next.cur = blk_inc(r_reg.cur);
                           end
                           STATUS_QUERY_CMD: begin
                              r_next.rdk = RD_STAT;
                           end
                           default: begin
                              ok = 1'b0; // unknown code, nack
                           end
                        endcase
                     end
                     P_ARG1: begin
                        r_next.ps = P_CMD;
                        unique case (r_reg.cmd)
                           SINGLE_BYTE_PROGRAM_CMD: begin
                              // offset now, value next
                              r_next.rd_adr = {r_reg.cur.page, r_reg.sh};
                              r_next.ps = P_ARG2;
                              r_next.pend = 1'b1;
                              r_next.preq = '{OP_CLR_BYTE,
                                 {r_reg.cur.page, r_reg.sh}, 8'h00};
                           end
                           BLOCK_CLEAR_CMD: begin
                              r_next.pend = 1'b1;
                              r_next.preq = '{OP_CLR_BLOCK,
                                 {r_reg.cur.page, r_reg.sh[7:5], 5'h00},
                                 8'h00};
                              r_next.hold = T_E;
                           end
                           SINGLE_BYTE_CLEAR_CMD: begin
                              r_next.pend = 1'b1;
                              r_next.preq = '{OP_CLR_BYTE,
                                 {r_reg.cur.page, r_reg.sh}, 8'h00};
                              r_next.hold = T_E;
                           end
                           ADDRESSED_READ_CMD: begin
                              r_next.rd_adr = {r_reg.cur.page, r_reg.sh};
                              r_next.rdk = RD_MEM;
                           end
                           default: begin
                              r_next.cur.page = r_reg.sh[5:0];
                           end
                        endcase
                     end
                     P_ARG2: begin
                        // value of byte program
                        r_next.ps = P_CMD;
                        r_next.pend = 1'b1;
                        r_next.preq = '{OP_PROG, r_reg.rd_adr, r_reg.sh};
                        r_next.hold = T_EP;
                     end
                     P_DATA: begin
                        r_next.pend = 1'b1;
                        r_next.preq = '{OP_PROG,
                           {r_reg.cur.page, r_reg.cur.blk, r_reg.idx}, r_reg.sh};
                        r_next.idx = r_reg.idx + 5'h01;
                        if (r_reg.idx == LAST_BYTE) begin
                           r_next.ps = P_CMD;
                           r_next.hold = (r_reg.cmd == ERASE_THEN_WRITE_BLOCK_CMD) ?
                              T_EP : T_P;
                        end
                     end
                  endcase
               end
               r_next.ack = ok;
               if (!ok) begin
                  r_next.ps = P_CMD;
               end
            end
         end
         S_RACK: begin
            // end of ack bit: stretch if work queued
            if (fall) begin
               r_next.ack = 1'b0;
               r_next.st = (r_reg.pend || r_reg.hold != '0) ? S_HOLD : S_RX;
            end
         end
         S_HOLD: begin
            // scl held low here
            if (r_reg.pend) begin
               if (r_reg.fill != 2'h2 || pop) begin
                  r_next.pend = 1'b0;
               end
            end else if (r_reg.hold == '0) begin
               r_next.st = S_RX;
            end else begin
               r_next.hold = r_reg.hold - 1'b1;
            end
         end
         S_TX: begin
            if (fall) begin
               r_next.tx = {r_reg.tx[6:0], 1'b0};
               r_next.bitn = r_reg.bitn + 4'h1;
               if (r_reg.bitn == 4'h7) begin
                  r_next.st = S_TACK;
               end
            end
         end
         S_TACK: begin
            // master answers, then stops
            if (rise) begin
               r_next.st = S_IDLE;
            end
         end
      endcase
      // buffer fill from held request
      if (r_reg.st == S_HOLD && r_reg.pend && (r_reg.fill != 2'h2 || pop)) begin
         fidx = pop ? r_reg.fill - 2'h1 : r_reg.fill;
         r_next.q[fidx[0]] = r_reg.preq;
         r_next.fill = fidx + 2'h1;
      end else if (pop) begin
         r_next.fill = r_reg.fill - 2'h1;
      end
      // start or stop restart the link, except while in S_HOLD
      if (r_reg.st != S_HOLD) begin
         if (start) begin
            r_next.st = S_ADDR;
            r_next.bitn = 4'h0;
            r_next.ack = 1'b0;
         end else if (stop) begin
            r_next.st = S_IDLE;
            r_next.ack = 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         r_reg <= '0;
         r_reg.cur <= RESET_PTR;
         r_reg.scl_sy <= 2'h3;
         r_reg.sda_sy <= 2'h3;
         r_reg.scl_q <= 1'b1;
         r_reg.sda_q <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   ////////////////////////////////////////////////////////////
   // outputs

   // open drain: only ever pull low
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;
   // stretch while storage runs
   assign scl_oe = (r_reg.st == S_HOLD);
   // ack low, or a zero data bit
   assign sda_oe = ((r_reg.st == S_AACK || r_reg.st == S_RACK) && r_reg.ack) ||
      (r_reg.st == S_TX && !r_reg.tx[7]);
   assign mem_valid = (r_reg.fill != 2'h0);
   assign mem_req = r_reg.q[0];
   assign mem_rd_addr = r_reg.rd_adr;
   assign locked = r_reg.locked;

endmodule : ipe_isp_engine

`default_nettype wire

//--- ipe_isp_engine_props.sv
/*
 ipe_isp_engine_chk: port timing checks of the programming engine.
 assumes a bind onto ipe_isp_engine, hold counts passed on as parameters.
*/
`default_nettype none

module ipe_isp_engine_chk
   import ipe_pkg::*;
#(
   parameter int ERASE_CYC = 200,
   parameter int PROG_CYC = 250
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic scl_i,
   input wire logic scl_oe,
   input wire logic sda_oe,
   input wire logic mem_valid,
   input wire logic mem_ready,
   input wire ipe_mem_req_t mem_req,
   input wire logic locked
);
   timeunit 1ns;
   timeprecision 1ps;
   int hold_cnt; // cycles of the current stretch
   logic saw_clr_all; // full clear queued in this stretch

   ////////////////////////////////////////////////////////////////////////
   // stretch length and content tracking
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         hold_cnt <= 0;
         saw_clr_all <= 1'b0;
      end else begin
         hold_cnt <= scl_oe ? hold_cnt + 1 : 0;
         saw_clr_all <= scl_oe && (saw_clr_all || (mem_valid && mem_req.op == OP_CLR_ALL));
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);

   a_req_holds: assert property (mem_valid && !mem_ready |=> mem_valid && $stable(mem_req))
      else $error("request changed before it was taken");
   a_clear_all_hold: assert property ($fell(scl_oe) && saw_clr_all |-> hold_cnt >= ERASE_CYC)
      else $error("full clear stretch too short");
   a_hold_bounded: assert property (scl_oe |-> hold_cnt < ERASE_CYC + PROG_CYC + 1000)
      else $error("scl stretch too long");
   a_clear_unlocks: assert property (mem_valid && mem_ready && mem_req.op == OP_CLR_ALL
      |-> ##[0:4] !locked)
      else $error("lock kept after full clear");
   a_block_aligned: assert property (mem_valid && mem_req.op == OP_CLR_BLOCK
      |-> mem_req.addr[4:0] == 5'h00)
      else $error("block clear not block aligned");
   a_req_in_stretch: assert property ($rose(mem_valid) |-> scl_oe || $past(scl_oe))
      else $error("request queued without stretch");
   a_reset_quiet: assert property ($rose(rstn) |-> !scl_oe && !sda_oe && !mem_valid)
      else $error("outputs active right after reset");
   a_sda_scl_low: assert property ($changed(sda_oe) |-> !scl_i)
      else $error("sda changed while scl high");

   c_clear_all: cover property ($fell(scl_oe) && saw_clr_all);
   c_stall: cover property (mem_valid && !mem_ready);
   c_block_clear: cover property (mem_valid && mem_req.op == OP_CLR_BLOCK);
endmodule : ipe_isp_engine_chk

bind ipe_isp_engine ipe_isp_engine_chk #(.ERASE_CYC(ERASE_CYC), .PROG_CYC(PROG_CYC)) u_chk (
   .clk(clk), .rstn(rstn), .scl_i(scl_i), .scl_oe(scl_oe), .sda_oe(sda_oe),
   .mem_valid(mem_valid), .mem_ready(mem_ready), .mem_req(mem_req), .locked(locked));

`default_nettype wire

//--- ipe_pkg.sv
/*
 ipe_pkg: constants and types of the isp programming engine.
 assumes a 100 MHz core clock and a 14-bit memory address
 made of page, block and byte fields.
*/
`default_nettype none

package ipe_pkg;
   // core clock rate
   localparam int CLK_MHZ = 100;
   // storage times, in microseconds
   localparam int ERASE_TIME_US = 2000;
   localparam int PROG_TIME_US = 2500;
   // derived cycle counts (exact at this rate)
   localparam int ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;
   localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
   // width of the hold counter
   localparam int HOLD_W = 20;
   // fixed 7-bit slave address and mode code
   localparam logic [6:0] SLAVE_ADDR = 7'h50;
   localparam logic [7:0] MODE_CODE = 8'h00;
   // command codes
   localparam logic [7:0] ERASE_THEN_WRITE_BLOCK_CMD = 8'h01;
   localparam logic [7:0] SINGLE_BYTE_PROGRAM_CMD = 8'h02;
   localparam logic [7:0] BLOCK_CLEAR_CMD = 8'h03;
   localparam logic [7:0] SINGLE_BYTE_CLEAR_CMD = 8'h04;
   localparam logic [7:0] ADDRESSED_READ_CMD = 8'h05;
   localparam logic [7:0] FULL_MEMORY_CLEAR_CMD = 8'h09;
   localparam logic [7:0] NO_ERASE_BLOCK_PROGRAM_CMD = 8'h0b;
   localparam logic [7:0] LOAD_PAGE_POINTER_CMD = 8'h0c;
   localparam logic [7:0] SEQUENTIAL_READ_CMD = 8'h0d;
   localparam logic [7:0] ADVANCE_BLOCK_POINTER_CMD = 8'h0f;
   localparam logic [7:0] STATUS_QUERY_CMD = 8'h13;
   // pointer after entry: page 48, block 3, byte 0
   localparam logic [5:0] RESET_PAGE = 6'h30;
   localparam logic [2:0] RESET_BLOCK = 3'h3;
   localparam logic [4:0] RESET_BYTE = 5'h00;
   // limits of auto increment
   localparam logic [5:0] LAST_SEQ_PAGE = 6'h1f;
   localparam logic [2:0] LAST_BLOCK = 3'h7;
   localparam logic [4:0] LAST_BYTE = 5'h1f;
   // memory operations handed to the array
   typedef enum logic [1:0] {
      OP_PROG, OP_CLR_BYTE, OP_CLR_BLOCK, OP_CLR_ALL
   } ipe_op_t;
   // one memory request
   typedef struct packed {
      ipe_op_t op;
      logic [13:0] addr;
      logic [7:0] data;
   } ipe_mem_req_t;
   // current pointer
   typedef struct packed {
      logic [5:0] page;
      logic [2:0] blk;
      logic [4:0] byt;
   } ipe_ptr_t;
endpackage : ipe_pkg

`default_nettype wire

//--- ipe_prog_master.sv
/*
 ipe_prog_master: behavioural i2c programmer, 17 clk per bit.
 assumes open-drain wires with pull-ups resolved by the bench.
*/
`default_nettype none

module ipe_prog_master (
   input wire logic clk,
   input wire logic scl,
   input wire logic sda,
   output var logic scl_rel,
   output var logic sda_rel
);
   timeunit 1ns;
   timeprecision 1ps;
   int max_wait; // longest stretch since cleared
   int hangs; // stretches that never ended

   initial begin
      scl_rel = 1'b1;
      sda_rel = 1'b1;
      max_wait = 0;
      hangs = 0;
   end

   task automatic half();
      repeat (8) @(negedge clk);
   endtask : half

   // release scl and wait out any stretch
   task automatic rise();
      int w;
      w = 0;
      scl_rel = 1'b1;
      @(negedge clk);
      while (!scl && w < 6000) begin
         w++;
         @(negedge clk);
      end
      if (w >= 6000) hangs++;
      if (w > max_wait) max_wait = w;
   endtask : rise

   // one bit: sda set with scl low, sampled mid high
   task automatic bit_io(input logic b, output logic s);
      sda_rel = b;
      half();
      rise();
      repeat (4) @(negedge clk);
      s = sda;
      repeat (4) @(negedge clk);
      scl_rel = 1'b0;
   endtask : bit_io

   task automatic start();
      sda_rel = 1'b1;
      half();
      rise();
      half();
      sda_rel = 1'b0;
      half();
      scl_rel = 1'b0;
   endtask : start

   task automatic stop();
      sda_rel = 1'b0;
      half();
      rise();
      half();
      sda_rel = 1'b1;
      half();
   endtask : stop

   // byte out, msb first, returns ack
   task automatic put(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(d[i], s);
      bit_io(1'b1, s);
      ack = !s;
   endtask : put

   // byte in, answered by no ack
   task automatic get(output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, s);
         d[i] = s;
      end
      bit_io(1'b1, s);
   endtask : get
endmodule : ipe_prog_master

`default_nettype wire

//--- ipe_tb.sv
/*
 testbench: programming sessions against ipe_isp_engine.
 assumes shortened hold counts and a memory model with stalls.
*/
`default_nettype none

module testbench;
   import ipe_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int EC = 200; // shortened erase hold
   localparam int PC = 250; // shortened program hold
   logic clk, rstn, mem_ready, lock_at_entry, locked, scl_o, scl_oe, sda_o, sda_oe;
   logic m_scl, m_sda, mem_valid;
   ipe_mem_req_t mem_req;
   logic [13:0] mem_rd_addr;
   logic [7:0] mem_rd_data;
   logic [7:0] mem [16384]; // memory array model
   int errors, cmp_count, cyc, stall_until;
   wire logic scl = m_scl && !scl_oe; // pull-up wire
   wire logic sda = m_sda && !sda_oe;

   ipe_isp_engine #(.ERASE_CYC(EC), .PROG_CYC(PC)) u_ipe_isp_engine (.clk(clk), .rstn(rstn),
      .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
      .mem_valid(mem_valid), .mem_ready(mem_ready), .mem_req(mem_req),
      .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data),
      .lock_at_entry(lock_at_entry), .locked(locked));
   ipe_prog_master u_ipe_prog_master (.clk(clk), .scl(scl), .sda(sda), .scl_rel(m_scl),
      .sda_rel(m_sda));

   function automatic logic [7:0] pat(input int a);
      // page bits folded in so a wrong page shows up in the data
      return 8'(a) ^ 8'(a >> 8) ^ 8'h5a;
   endfunction : pat

   ////////////////////////////////////////////////////////////////////////
   // memory side: ready 3 of 4 cycles, stalls on request
   assign mem_rd_data = mem[mem_rd_addr];
   always @(negedge clk) begin
      cyc <= cyc + 1;
      mem_ready <= (cyc >= stall_until) && (cyc[1:0] != 2'h0);
   end
   always @(posedge clk) begin
      if (mem_valid && mem_ready) begin
         case (mem_req.op)
            OP_PROG: mem[mem_req.addr] = mem_req.data;
            OP_CLR_BYTE: mem[mem_req.addr] = 8'h00;
            OP_CLR_BLOCK: for (int i = 0; i < 32; i++) mem[{mem_req.addr[13:5], 5'(i)}] = 8'h00;
            default: for (int i = 0; i < 16384; i++) mem[i] = 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // helpers
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] b, input logic exp_ack);
      logic a;
      u_ipe_prog_master.put(b, a);
      chk(32'(a), 32'(exp_ack));
   endtask : wr

   // restart for reading, take one byte, readdress for writing
   task automatic rd_back(input logic [7:0] exp);
      logic [7:0] d;
      u_ipe_prog_master.stop();
      u_ipe_prog_master.start();
      wr(8'ha1, 1'b1);
      u_ipe_prog_master.get(d);
      u_ipe_prog_master.stop();
      chk(32'(d), 32'(exp));
      u_ipe_prog_master.start();
      wr(8'ha0, 1'b1);
   endtask : rd_back

   // send a byte and judge the stretch that preceded it
   // the master only counts after its own half period, 4 clk short of the hold
   task automatic wr_hold(input logic [7:0] b, input int lo);
      u_ipe_prog_master.max_wait = 0;
      wr(b, 1'b1);
      chk(32'(u_ipe_prog_master.max_wait + 4 >= lo && u_ipe_prog_master.max_wait < lo + 60), 32'h1);
   endtask : wr_hold

   ////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic sc_entry();
      u_ipe_prog_master.start();
      wr(8'ha2, 1'b0);
      u_ipe_prog_master.stop();
      u_ipe_prog_master.start();
      wr(8'ha0, 1'b1);
      wr(8'h00, 1'b1);
      wr(8'h77, 1'b0);
      wr(SEQUENTIAL_READ_CMD, 1'b1);
      rd_back(pat(14'h3060));
      wr(SEQUENTIAL_READ_CMD, 1'b1);
      rd_back(pat(14'h3061));
      wr(STATUS_QUERY_CMD, 1'b1);
      rd_back(8'h80);
   endtask : sc_entry

   task automatic sc_wrap();
      // page 48 block 3 byte 2: five steps carry into page 49
      repeat (5) wr(ADVANCE_BLOCK_POINTER_CMD, 1'b1);
      wr(SEQUENTIAL_READ_CMD, 1'b1);
      rd_back(pat(14'h3102));
      wr(LOAD_PAGE_POINTER_CMD, 1'b1);
      wr(8'h1f, 1'b1);
      repeat (8) wr(ADVANCE_BLOCK_POINTER_CMD, 1'b1);
      wr(SEQUENTIAL_READ_CMD, 1'b1);
      rd_back(pat(0));
   endtask : sc_wrap

   task automatic sc_program();
      logic [7:0] v;
      wr(FULL_MEMORY_CLEAR_CMD, 1'b1);
      wr_hold(ADVANCE_BLOCK_POINTER_CMD, EC);
      chk(32'(locked), 32'h0);
      repeat (7) wr(ADVANCE_BLOCK_POINTER_CMD, 1'b1);
      wr(LOAD_PAGE_POINTER_CMD, 1'b1);
      wr(8'h02, 1'b1);
      wr(NO_ERASE_BLOCK_PROGRAM_CMD, 1'b1);
      for (int i = 0; i < 32; i++) wr(8'h80 + 8'(i), 1'b1);
      wr_hold(LOAD_PAGE_POINTER_CMD, PC);
      for (int i = 0; i < 32; i++) chk(32'(mem[14'h0200 + i]), 32'h80 + i);
      wr(8'h30, 1'b1);
      wr(ERASE_THEN_WRITE_BLOCK_CMD, 1'b1);
      stall_until = cyc + 600;
      for (int i = 0; i < 32; i++) wr(i < 8 ? 8'hc0 + 8'(i) : 8'h11, 1'b1);
      wr_hold(SINGLE_BYTE_PROGRAM_CMD, EC + PC);
      wr(8'h45, 1'b1);
      wr(8'ha7, 1'b1);
      wr_hold(SINGLE_BYTE_CLEAR_CMD, EC + PC);
      wr(8'h03, 1'b1);
      wr(LOAD_PAGE_POINTER_CMD, 1'b1);
      wr(8'h02, 1'b1);
      wr(BLOCK_CLEAR_CMD, 1'b1);
      wr(8'h1f, 1'b1);
      wr(LOAD_PAGE_POINTER_CMD, 1'b1);
      wr(8'h30, 1'b1);
      wr(ADDRESSED_READ_CMD, 1'b1);
      wr(8'h45, 1'b1);
      rd_back(8'ha7);
      for (int i = 0; i < 32; i++) begin
         v = (i == 3) ? 8'h00 : (i < 8 ? 8'hc0 + 8'(i) : 8'h11);
         chk(32'(mem[14'h3000 + i]), 32'(v));
         chk(32'(mem[14'h0200 + i]), 32'h0);
      end
      u_ipe_prog_master.stop();
   endtask : sc_program

   ////////////////////////////////////////////////////////////////////////
   // verdict
   task automatic close_out();
      errors += u_ipe_prog_master.hangs;
      $display("comparisons %0d, mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : close_out

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial begin
      repeat (60000) @(posedge clk);
      errors++;
      $display("mismatch at %0t: watchdog expired", $time);
      close_out();
   end

   initial begin
      rstn = 1'b0;
      lock_at_entry = 1'b1;
      mem_ready = 1'b0;
      errors = 0;
      cmp_count = 0;
      cyc = 0;
      stall_until = 0;
      for (int i = 0; i < 16384; i++) mem[i] = pat(i);
      repeat (5) @(negedge clk);
      rstn = 1'b1;
      repeat (8) @(negedge clk);
      chk(32'(locked), 32'h1);
      chk(32'({scl_o, sda_o}), 32'h0);
      sc_entry();
      sc_wrap();
      sc_program();
      close_out();
   end
endmodule : testbench

`default_nettype wire
